// ==== pkg/amp_pwr_pkg.sv ====
// constants, enumerations and timing counts for the amplifier power and mode control
// What this block does
// - format strap low selects one-bit pulse-density, high selects multibit PCM
// - PCM serial port framing is I2S, left-justified or TDM
// - control by I2C, pattern control, TDM control or standalone operation
// - soft power-down under I2C or TDM control powers down all but the control interface
// - standby command under pattern control leaves only the pulse-density and control interfaces on
// - absent bit clock powers down all circuitry but the control interface
// - returning bit clock restarts the normal power-up sequence automatically
// - optional auto power-down after 2048 zero PCM samples keeps control and input
// - separate bits switch off current, voltage and battery sense paths
// - separate bits power down amplifier and boost converter independently
// - boost off with amplifier on runs amplifier from the battery
// - battery direct bit runs amplifier from battery with boost kept on
// - amplifier may be off while boost stays enabled
// - low battery or I/O supply holds all internal circuitry in reset
// - supply drop while running stops the amplifier and issues internal reset
package amp_pwr_pkg;

  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int CLK_LOSS_NS        = 2000;
  localparam int CLK_LOSS_CYCLES    = (CLK_LOSS_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int POWERUP_STEP_NS    = 1000;
  localparam int POWERUP_STEP_CYCLES =
    (POWERUP_STEP_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int ZERO_RUN_SAMPLES   = 2048;

  localparam logic FORMAT_PIN_PDM = 1'h0;

  typedef enum logic [2:0] {
    ST_RESET     = 3'h0,
    ST_OFF       = 3'h1,
    ST_BOOST_UP  = 3'h2,
    ST_AMP_UP    = 3'h3,
    ST_RUN       = 3'h4,
    ST_STANDBY   = 3'h5,
    ST_AUTO_LOW  = 3'h6
  } pwr_state_e;

  typedef enum logic [1:0] {
    CTRL_I2C        = 2'h0,
    CTRL_PATTERN    = 2'h1,
    CTRL_TDM        = 2'h2,
    CTRL_STANDALONE = 2'h3
  } ctrl_mode_e;

  typedef enum logic [1:0] {
    FRAME_I2S  = 2'h0,
    FRAME_LJ   = 2'h1,
    FRAME_TDM  = 2'h2,
    FRAME_RSVD = 2'h3
  } framing_e;

endpackage

// ==== rtl/clock_watch.sv ====
// bit clock synchroniser, edge finder and loss timeout
`timescale 1ns/100ps
module clock_watch #(
  parameter int TIMEOUT_CYCLES = amp_pwr_pkg::CLK_LOSS_CYCLES
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_link_clk,
  output logic      o_present,
  output logic      o_edge
);
  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

  if (TIMEOUT_CYCLES < 2) begin : g_chk
    $error("clock_watch timeout must be at least two cycles");
  end

  typedef struct packed {
    logic          meta;
    logic          sync;
    logic          prev;
    logic [CW-1:0] count;
    logic          present;
  } watch_s;

  watch_s r_reg;
  watch_s r_next;
  logic   edge_seen;

  assign edge_seen = r_reg.sync ^ r_reg.prev;

  always_comb begin
    r_next      = r_reg;
    r_next.meta = i_link_clk;
    r_next.sync = r_reg.meta;
    r_next.prev = r_reg.sync;
    if (edge_seen) begin
      r_next.count   = '0;
      r_next.present = 1'b1;
    end else if (r_reg.count == CW'(TIMEOUT_CYCLES)) begin
      r_next.present = 1'b0;
    end else begin
      r_next.count = r_reg.count + CW'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_present = r_reg.present;
  assign o_edge    = edge_seen;
endmodule

// ==== rtl/amp_power_mode_control.sv ====
// power, mode and reset supervision for the boosted audio amplifier
`timescale 1ns/100ps
module amp_power_mode_control #(
  parameter int CLK_LOSS_CYCLES  = amp_pwr_pkg::CLK_LOSS_CYCLES,
  parameter int STEP_CYCLES      = amp_pwr_pkg::POWERUP_STEP_CYCLES,
  parameter int ZERO_RUN_SAMPLES = amp_pwr_pkg::ZERO_RUN_SAMPLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_input_bit_clock_pin,
  input  wire logic       i_format_sel_pin,
  input  wire logic       i_batt_supply_ok,
  input  wire logic       i_io_supply_ok,
  input  wire logic [1:0] i_ctrl_mode,
  input  wire logic [1:0] i_serial_framing,
  input  wire logic       i_soft_power_down,
  input  wire logic       i_standby_cmd,
  input  wire logic       i_auto_pd_en,
  input  wire logic       i_sample_strobe,
  input  wire logic       i_sample_zero,
  input  wire logic       i_current_sense_off,
  input  wire logic       i_voltage_sense_off,
  input  wire logic       i_battery_sense_off,
  input  wire logic       i_amplifier_off,
  input  wire logic       i_booster_off,
  input  wire logic       i_battery_direct,
  output logic            o_pdm_format,
  output logic [1:0]      o_serial_framing,
  output logic [1:0]      o_ctrl_mode,
  output logic            o_internal_reset_n,
  output logic            o_bit_clock_present,
  output logic            o_boost_en,
  output logic            o_amp_en,
  output logic            o_amp_from_battery,
  output logic            o_current_sense_en,
  output logic            o_voltage_sense_en,
  output logic            o_battery_sense_en,
  output logic            o_audio_input_en,
  output logic            o_pdm_if_en,
  output logic            o_ctrl_if_en,
  output logic [2:0]      o_state
);
  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam int ZW = $clog2(ZERO_RUN_SAMPLES + 1);

  if (STEP_CYCLES < 1 || ZERO_RUN_SAMPLES < 2) begin : g_chk
    $error("amp_power_mode_control parameters out of range");
  end

  typedef struct packed {
    amp_pwr_pkg::pwr_state_e state;
    logic [2:0]              meta;
    logic [2:0]              sync;
    logic                    strap_done;
    logic                    pdm_format;
    logic [1:0]              framing;
    logic [1:0]              ctrl_mode;
    logic [SW-1:0]           step_cnt;
    logic [ZW-1:0]           zero_cnt;
    logic                    int_reset_n;
    logic                    boost_en;
    logic                    amp_en;
    logic                    amp_batt;
    logic                    cur_sense_en;
    logic                    volt_sense_en;
    logic                    batt_sense_en;
    logic                    audio_en;
    logic                    pdm_if_en;
    logic                    ctrl_if_en;
  } ctl_s;

  ctl_s r_reg;
  ctl_s r_next;
  logic clk_present;
  logic supply_ok;
  logic soft_pd;
  logic standby;

  clock_watch #(
    .TIMEOUT_CYCLES (CLK_LOSS_CYCLES)
  ) u_clock_watch (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_link_clk (i_input_bit_clock_pin),
    .o_present  (clk_present),
    .o_edge     ()
  );

  // sync bits: 0 battery ok, 1 io ok, 2 format strap
  assign supply_ok = r_reg.sync[0] & r_reg.sync[1];
  assign soft_pd   = i_soft_power_down &
                     (i_ctrl_mode == amp_pwr_pkg::CTRL_I2C ||
                      i_ctrl_mode == amp_pwr_pkg::CTRL_TDM);
  assign standby   = i_standby_cmd & (i_ctrl_mode == amp_pwr_pkg::CTRL_PATTERN);

  always_comb begin
    r_next      = r_reg;
    r_next.meta = {i_format_sel_pin, i_io_supply_ok, i_batt_supply_ok};
    r_next.sync = r_reg.meta;
    r_next.ctrl_mode = i_ctrl_mode;
    if (r_reg.pdm_format) begin
      r_next.framing = amp_pwr_pkg::FRAME_I2S;
    end else if (i_serial_framing == amp_pwr_pkg::FRAME_RSVD) begin
      r_next.framing = amp_pwr_pkg::FRAME_I2S;
    end else begin
      r_next.framing = i_serial_framing;
    end

    if (!supply_ok) begin
      r_next.state      = amp_pwr_pkg::ST_RESET;
      r_next.strap_done = 1'b0;
      r_next.step_cnt   = '0;
      r_next.zero_cnt   = '0;
    end else begin
      if (!r_reg.strap_done) begin
        r_next.strap_done = 1'b1;
        r_next.pdm_format = (r_reg.sync[2] == amp_pwr_pkg::FORMAT_PIN_PDM);
      end
      case (r_reg.state)
        amp_pwr_pkg::ST_RESET: begin
          if (r_reg.strap_done) begin
            r_next.state = amp_pwr_pkg::ST_OFF;
          end
        end
        amp_pwr_pkg::ST_OFF: begin
          if (clk_present && !soft_pd) begin
            r_next.state    = amp_pwr_pkg::ST_BOOST_UP;
            r_next.step_cnt = '0;
          end
        end
        amp_pwr_pkg::ST_BOOST_UP, amp_pwr_pkg::ST_AMP_UP: begin
          if (r_reg.step_cnt == SW'(STEP_CYCLES - 1)) begin
            r_next.step_cnt = '0;
            r_next.state    = (r_reg.state == amp_pwr_pkg::ST_BOOST_UP) ?
                              amp_pwr_pkg::ST_AMP_UP : amp_pwr_pkg::ST_RUN;
            r_next.zero_cnt = '0;
          end else begin
            r_next.step_cnt = r_reg.step_cnt + SW'(1);
          end
        end
        amp_pwr_pkg::ST_RUN: begin
          if (standby) begin
            r_next.state = amp_pwr_pkg::ST_STANDBY;
          end else if (i_sample_strobe) begin
            if (!i_sample_zero) begin
              r_next.zero_cnt = '0;
            end else if (r_reg.zero_cnt == ZW'(ZERO_RUN_SAMPLES - 1)) begin
              r_next.zero_cnt = '0;
              if (i_auto_pd_en && !r_reg.pdm_format) begin
                r_next.state = amp_pwr_pkg::ST_AUTO_LOW;
              end
            end else begin
              r_next.zero_cnt = r_reg.zero_cnt + ZW'(1);
            end
          end
        end
        amp_pwr_pkg::ST_STANDBY: begin
          if (!standby) begin
            r_next.state    = amp_pwr_pkg::ST_BOOST_UP;
            r_next.step_cnt = '0;
          end
        end
        amp_pwr_pkg::ST_AUTO_LOW: begin
          if (!i_auto_pd_en || (i_sample_strobe && !i_sample_zero)) begin
            r_next.state    = amp_pwr_pkg::ST_BOOST_UP;
            r_next.step_cnt = '0;
          end
        end
        default: begin
          r_next.state = amp_pwr_pkg::ST_RESET;
        end
      endcase
      if (r_reg.state != amp_pwr_pkg::ST_RESET &&
          r_reg.state != amp_pwr_pkg::ST_OFF && (!clk_present || soft_pd)) begin
        r_next.state = amp_pwr_pkg::ST_OFF;
      end
    end

    // block enables follow the next state
    r_next.int_reset_n = supply_ok && r_next.state != amp_pwr_pkg::ST_RESET;
    r_next.ctrl_if_en  = r_next.int_reset_n;
    r_next.boost_en    = 1'b0;
    r_next.amp_en      = 1'b0;
    r_next.audio_en    = 1'b0;
    r_next.pdm_if_en   = 1'b0;
    case (r_next.state)
      amp_pwr_pkg::ST_BOOST_UP: begin
        r_next.boost_en = !i_booster_off;
        r_next.audio_en = 1'b1;
        r_next.pdm_if_en = r_reg.pdm_format;
      end
      amp_pwr_pkg::ST_AMP_UP, amp_pwr_pkg::ST_RUN: begin
        r_next.boost_en  = !i_booster_off;
        r_next.amp_en    = (r_next.state == amp_pwr_pkg::ST_RUN) && !i_amplifier_off;
        r_next.audio_en  = 1'b1;
        r_next.pdm_if_en = r_reg.pdm_format;
      end
      amp_pwr_pkg::ST_STANDBY: begin
        r_next.pdm_if_en = 1'b1;
      end
      amp_pwr_pkg::ST_AUTO_LOW: begin
        r_next.audio_en  = 1'b1;
        r_next.pdm_if_en = r_reg.pdm_format;
      end
      default: begin
        r_next.boost_en = 1'b0;
      end
    endcase
    r_next.amp_batt = r_next.amp_en & (i_booster_off | i_battery_direct);
    r_next.cur_sense_en  = r_next.amp_en & !i_current_sense_off;
    r_next.volt_sense_en = r_next.amp_en & !i_voltage_sense_off;
    r_next.batt_sense_en = r_next.amp_en & !i_battery_sense_off;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_pdm_format        = r_reg.pdm_format;
  assign o_serial_framing    = r_reg.framing;
  assign o_ctrl_mode         = r_reg.ctrl_mode;
  assign o_internal_reset_n  = r_reg.int_reset_n;
  assign o_bit_clock_present = clk_present;
  assign o_boost_en          = r_reg.boost_en;
  assign o_amp_en            = r_reg.amp_en;
  assign o_amp_from_battery  = r_reg.amp_batt;
  assign o_current_sense_en  = r_reg.cur_sense_en;
  assign o_voltage_sense_en  = r_reg.volt_sense_en;
  assign o_battery_sense_en  = r_reg.batt_sense_en;
  assign o_audio_input_en    = r_reg.audio_en;
  assign o_pdm_if_en         = r_reg.pdm_if_en;
  assign o_ctrl_if_en        = r_reg.ctrl_if_en;
  assign o_state             = r_reg.state;
endmodule

// ==== tb/host_bit_clock.sv ====
// host side bit clock source that stands still while stopped
`timescale 1ns/100ps
module host_bit_clock (
  input  wire logic i_run,
  input  wire logic i_slow,
  output logic      o_bit_clk,
  output logic      o_frame_clk
);
  initial begin
    o_bit_clk   = 1'h0;
    o_frame_clk = 1'h0;
    #7;
    forever begin
      #(i_slow ? 84 : 24);
      if (i_run) begin
        o_bit_clk   = !o_bit_clk;
        o_frame_clk = o_bit_clk;
      end
    end
  end
endmodule

// ==== tb/amp_pmc_properties.sv ====
// port assertions for the power and mode control
`timescale 1ns/100ps
module amp_pmc_checker (
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic       i_batt_supply_ok,
  input wire logic       i_io_supply_ok,
  input wire logic       i_soft_power_down,
  input wire logic [1:0] i_serial_framing,
  input wire logic       i_current_sense_off,
  input wire logic       i_amplifier_off,
  input wire logic       i_booster_off,
  input wire logic       i_battery_direct,
  input wire logic       o_pdm_format,
  input wire logic [1:0] o_serial_framing,
  input wire logic       o_internal_reset_n,
  input wire logic       o_bit_clock_present,
  input wire logic       o_boost_en,
  input wire logic       o_amp_en,
  input wire logic       o_amp_from_battery,
  input wire logic       o_current_sense_en,
  input wire logic       o_audio_input_en,
  input wire logic       o_ctrl_if_en,
  input wire logic [2:0] o_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_SUPPLY_DROP: assert property (!(i_batt_supply_ok && i_io_supply_ok) |-> ##3
    (!o_internal_reset_n && !o_amp_en && !o_boost_en)) else $error("supply drop unanswered");
  AST_RESET_HOLD: assert property (!o_internal_reset_n |->
    (!o_amp_en && !o_boost_en && o_state == 3'h0)) else $error("enable during reset");
  AST_AMP_BIT: assert property (o_state == 3'h4 && $past(o_state) == 3'h4 |->
    o_amp_en == !$past(i_amplifier_off)) else $error("amplifier enable wrong");
  AST_BOOST_BIT: assert property (o_state == 3'h4 && $past(o_state) == 3'h4 |->
    o_boost_en == !$past(i_booster_off)) else $error("boost enable wrong");
  AST_BATTERY: assert property (o_state == 3'h4 && $past(o_state) == 3'h4 |->
    o_amp_from_battery == (o_amp_en && ($past(i_booster_off) || $past(i_battery_direct))))
    else $error("battery path wrong");
  AST_SENSE: assert property (o_state == 3'h4 && $past(o_state) == 3'h4 |->
    o_current_sense_en == (o_amp_en && !$past(i_current_sense_off))) else $error("sense wrong");
  AST_FRAMING: assert property (o_internal_reset_n && $past(o_internal_reset_n)
    && !o_pdm_format |-> o_serial_framing ==
    ($past(i_serial_framing) == 2'h3 ? 2'h0 : $past(i_serial_framing))) else $error("framing");
  AST_LOSS_OFF: assert property ($fell(o_bit_clock_present) && o_internal_reset_n |->
    ##1 (o_state == 3'h1 && !o_amp_en && !o_boost_en)) else $error("no power-down on loss");
  AST_RETURN_UP: assert property ($rose(o_bit_clock_present) && o_state == 3'h1
    && o_internal_reset_n && !i_soft_power_down |-> ##1 o_state == 3'h2) else $error("no restart");
  AST_AMP_WAITS: assert property (o_state == 3'h2 || o_state == 3'h3 |-> !o_amp_en)
    else $error("amplifier early");
  AST_AUTO_LOW: assert property (o_state == 3'h6 |-> !o_amp_en && !o_boost_en
    && o_audio_input_en && o_ctrl_if_en) else $error("auto low enables wrong");
endmodule
bind amp_power_mode_control amp_pmc_checker amp_pmc_checker_inst (.i_core_clk, .i_rst_n,
  .i_batt_supply_ok, .i_io_supply_ok, .i_soft_power_down, .i_serial_framing,
  .i_current_sense_off, .i_amplifier_off, .i_booster_off, .i_battery_direct, .o_pdm_format,
  .o_serial_framing, .o_internal_reset_n, .o_bit_clock_present, .o_boost_en, .o_amp_en,
  .o_amp_from_battery, .o_current_sense_en, .o_audio_input_en, .o_ctrl_if_en, .o_state);

// ==== tb/tb_amp_power_mode_control.sv ====
// self-checking bench for the amplifier power and mode control
`timescale 1ns/100ps
module tb_amp_power_mode_control;
  localparam int LOSS = 40;
  localparam int ZRUN = 8;
  logic i_core_clk, i_rst_n, i_input_bit_clock_pin, i_format_sel_pin, i_batt_supply_ok;
  logic i_io_supply_ok, i_soft_power_down, i_standby_cmd, i_auto_pd_en, i_sample_strobe;
  logic i_sample_zero, i_current_sense_off, i_voltage_sense_off, i_battery_sense_off;
  logic i_amplifier_off, i_booster_off, i_battery_direct, clk_run, clk_slow, a;
  logic [1:0] i_ctrl_mode, i_serial_framing, o_serial_framing, o_ctrl_mode;
  logic o_pdm_format, o_internal_reset_n, o_bit_clock_present, o_boost_en, o_amp_en;
  logic o_amp_from_battery, o_current_sense_en, o_voltage_sense_en, o_battery_sense_en;
  logic o_audio_input_en, o_pdm_if_en, o_ctrl_if_en;
  logic [2:0] o_state;
  logic [5:0] r;
  logic [7:0] got_v, exp_v;
  int bad_count = 0, checks_done = 0, seed = 96927, rv;
  amp_power_mode_control #(.CLK_LOSS_CYCLES(LOSS), .STEP_CYCLES(4), .ZERO_RUN_SAMPLES(ZRUN))
    amp_power_mode_control_inst (.i_core_clk, .i_rst_n, .i_input_bit_clock_pin,
    .i_format_sel_pin, .i_batt_supply_ok, .i_io_supply_ok, .i_ctrl_mode, .i_serial_framing,
    .i_soft_power_down, .i_standby_cmd, .i_auto_pd_en, .i_sample_strobe, .i_sample_zero,
    .i_current_sense_off, .i_voltage_sense_off, .i_battery_sense_off, .i_amplifier_off,
    .i_booster_off, .i_battery_direct, .o_pdm_format, .o_serial_framing, .o_ctrl_mode,
    .o_internal_reset_n, .o_bit_clock_present, .o_boost_en, .o_amp_en, .o_amp_from_battery,
    .o_current_sense_en, .o_voltage_sense_en, .o_battery_sense_en, .o_audio_input_en,
    .o_pdm_if_en, .o_ctrl_if_en, .o_state);
  host_bit_clock host_bit_clock_inst (.i_run(clk_run), .i_slow(clk_slow),
    .o_bit_clk(i_input_bit_clock_pin), .o_frame_clk());
  initial begin
    i_core_clk = 1'h0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_st(input logic [2:0] st, input int bound);
    for (int n = 0; n < bound && o_state !== st; n++) @(negedge i_core_clk);
    chk({5'h0, o_state}, {5'h0, st});
    if (o_state !== st) give_verdict();
  endtask
  task automatic strobe(input logic zero, input int n);
    repeat (n) begin
      i_sample_zero = zero;
      i_sample_strobe = 1'h1;
      @(negedge i_core_clk);
      i_sample_strobe = 1'h0;
      @(negedge i_core_clk);
    end
  endtask
  initial begin
    {i_rst_n, i_soft_power_down, i_standby_cmd, i_auto_pd_en, i_sample_strobe} = 5'h0;
    {i_sample_zero, i_current_sense_off, i_voltage_sense_off, i_battery_sense_off} = 4'h0;
    {i_amplifier_off, i_booster_off, i_battery_direct, clk_slow} = 4'h0;
    {i_format_sel_pin, i_batt_supply_ok, i_io_supply_ok, clk_run} = 4'hF;
    {i_ctrl_mode, i_serial_framing} = 4'h0;
    repeat (20) @(negedge i_core_clk);
    i_rst_n = 1'h1;
    wait_st(amp_pwr_pkg::ST_RUN, 200);
    chk({7'h0, o_pdm_format}, 8'h0);
    for (int f = 0; f < 4; f++) begin
      i_serial_framing = f[1:0];
      i_ctrl_mode = f[1:0];
      repeat (2) @(negedge i_core_clk);
      exp_v = {4'h0, f[1:0], f == 3 ? 2'h0 : f[1:0]};
      chk({4'h0, o_ctrl_mode, o_serial_framing}, exp_v);
    end
    i_ctrl_mode = 2'h0;
    $display("test modes done");
    for (int k = 0; k < 12; k++) begin
      rv = $random(seed);
      r = rv[5:0];
      {i_amplifier_off, i_booster_off, i_battery_direct} = r[5:3];
      {i_current_sense_off, i_voltage_sense_off, i_battery_sense_off} = r[2:0];
      a = !r[5];
      repeat (2) @(negedge i_core_clk);
      exp_v = {2'h0, a, !r[4], a & (r[4] | r[3]), a & !r[2], a & !r[1], a & !r[0]};
      got_v = {2'h0, o_amp_en, o_boost_en, o_amp_from_battery, o_current_sense_en,
        o_voltage_sense_en, o_battery_sense_en};
      chk(got_v, exp_v);
    end
    {i_amplifier_off, i_booster_off, i_battery_direct, i_current_sense_off} = 4'h0;
    {i_voltage_sense_off, i_battery_sense_off} = 2'h0;
    $display("test enables done");
    i_auto_pd_en = 1'h1;
    strobe(1'h1, ZRUN - 1);
    strobe(1'h0, 1);
    strobe(1'h1, ZRUN - 1);
    wait_st(amp_pwr_pkg::ST_RUN, 0);
    strobe(1'h1, 1);
    wait_st(amp_pwr_pkg::ST_AUTO_LOW, 4);
    chk({4'h0, o_amp_en, o_boost_en, o_audio_input_en, o_ctrl_if_en}, 8'h3);
    strobe(1'h0, 1);
    i_auto_pd_en = 1'h0;
    wait_st(amp_pwr_pkg::ST_RUN, 40);
    i_auto_pd_en = 1'h1;
    strobe(1'h1, ZRUN);
    wait_st(amp_pwr_pkg::ST_AUTO_LOW, 4);
    i_auto_pd_en = 1'h0;
    wait_st(amp_pwr_pkg::ST_RUN, 40);
    $display("test zero run done");
    i_ctrl_mode = 2'h1;
    i_soft_power_down = 1'h1;
    repeat (6) @(negedge i_core_clk);
    wait_st(amp_pwr_pkg::ST_RUN, 0);
    i_ctrl_mode = 2'h2;
    wait_st(amp_pwr_pkg::ST_OFF, 6);
    chk({7'h0, o_ctrl_if_en}, 8'h1);
    i_soft_power_down = 1'h0;
    wait_st(amp_pwr_pkg::ST_RUN, 40);
    i_ctrl_mode = 2'h1;
    i_standby_cmd = 1'h1;
    wait_st(amp_pwr_pkg::ST_STANDBY, 6);
    chk({6'h0, o_amp_en, o_boost_en}, 8'h0);
    i_standby_cmd = 1'h0;
    wait_st(amp_pwr_pkg::ST_RUN, 40);
    $display("test power-down done");
    clk_run = 1'h0;
    repeat (LOSS - 8) @(negedge i_core_clk);
    chk({7'h0, o_bit_clock_present}, 8'h1);
    wait_st(amp_pwr_pkg::ST_OFF, 30);
    clk_run = 1'h1;
    wait_st(amp_pwr_pkg::ST_RUN, 60);
    $display("test clock loss done");
    i_batt_supply_ok = 1'h0;
    i_format_sel_pin = 1'h0;
    clk_slow = 1'h1;
    repeat (4) @(negedge i_core_clk);
    chk({4'h0, o_internal_reset_n, o_state}, 8'h0);
    i_batt_supply_ok = 1'h1;
    wait_st(amp_pwr_pkg::ST_RUN, 300);
    chk({5'h0, o_pdm_format, o_pdm_if_en, o_amp_en}, 8'h7);
    i_auto_pd_en = 1'h1;
    strobe(1'h1, ZRUN);
    wait_st(amp_pwr_pkg::ST_RUN, 0);
    $display("test supply drop done");
    give_verdict();
  end
endmodule
